// file: src/lcas_blinker.sv
// Per-channel indicator driver: detection state or error blink bursts.
`timescale 1ns/1ps
`default_nettype none
`include "lcas_defines.svh"

module lcas_blinker
  import lcas_pkg::*;
#(
  parameter int BURST_CYC = 125000000, // Burst repeat period.
  parameter int BLINK_CYC = 5000000    // One blink on+off period.
) (
  input  wire logic      core_clk,  // System clock.
  input  wire logic      rst_n,     // Asynchronous reset, active low.
  input  wire lcas_err_t err_code,  // Channel error code.
  input  wire logic      aligning,  // Channel is aligning.
  input  wire logic      detect,    // Qualified detection state.
  output var  logic      led        // Channel indicator level.
);

  initial begin
    if (BLINK_CYC < 2 || BURST_CYC < 8 * BLINK_CYC) begin
      $error("lcas_blinker: burst too short for seven blinks");
    end
  end

  logic [31:0] burst_r;
  logic [31:0] burst_nxt;
  logic [31:0] blink_r;
  logic [31:0] blink_nxt;
  logic [2:0]  cnt_r;
  logic [2:0]  cnt_nxt;
  logic        led_r;
  logic        led_nxt;

  assign led = led_r;

  // =========================================================================
  // Burst timing
  // Each burst starts at a fresh period boundary; count of blinks equals
  // the error code, and the lamp is lit for the first half of each blink.
  always_comb begin
    burst_nxt = burst_r;
    blink_nxt = blink_r;
    cnt_nxt   = cnt_r;
    led_nxt   = 1'b0;
    if (err_code == `LCAS_ERR_NONE) begin
      burst_nxt = 32'h0000_0000;
      blink_nxt = 32'h0000_0000;
      cnt_nxt   = 3'h0;
      led_nxt   = aligning ? 1'b1 : detect;
    end else begin
      burst_nxt = (burst_r == 32'(BURST_CYC - 1)) ? 32'h0000_0000
                                                  : burst_r + 32'h0000_0001;
      if (burst_r == 32'h0000_0000) begin
        blink_nxt = 32'h0000_0000;
        cnt_nxt   = 3'h0;
      end else if (cnt_r != err_code) begin
        if (blink_r == 32'(BLINK_CYC - 1)) begin
          blink_nxt = 32'h0000_0000;
          cnt_nxt   = cnt_r + 3'h1;
        end else begin
          blink_nxt = blink_r + 32'h0000_0001;
        end
        led_nxt = (blink_r < 32'(BLINK_CYC / 2));
      end
    end
  end

  // Registers of the blink timer.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_r <= 32'h0000_0000;
      blink_r <= 32'h0000_0000;
      cnt_r   <= 3'h0;
      led_r   <= 1'b0;
    end else begin
      burst_r <= burst_nxt;
      blink_r <= blink_nxt;
      cnt_r   <= cnt_nxt;
      led_r   <= led_nxt;
    end
  end

endmodule
`default_nettype wire

// file: src/lcas_defines.svh
// Timing counts, error codes and clock constants for the loop alignment supervisor.
`ifndef LCAS_DEFINES_SVH
`define LCAS_DEFINES_SVH

`define LCAS_CLK_HZ        25000000
`define LCAS_ALIGN_MS      1000
`define LCAS_DISTURB_MS    2000
`define LCAS_BURST_MS      5000
`define LCAS_RECAL_MS      30000
`define LCAS_BLINK_MS      200
`define LCAS_FAST_HALF_MS  100
`define LCAS_NORM_HALF_MS  500
`define LCAS_SYNC_HALF_MS  1000
`define LCAS_PRESS_TOG_MS  1000
`define LCAS_PRESS_ALN_MS  2000
`define LCAS_PRESS_RST_MS  3000
`define LCAS_CYC_PER_MS    25000

`define LCAS_ERR_NONE      3'h0
`define LCAS_ERR_SHORT     3'h1
`define LCAS_ERR_OPEN      3'h2
`define LCAS_ERR_FREQ      3'h3
`define LCAS_ERR_DISTURB   3'h4
`define LCAS_ERR_PARTNER   3'h6
`define LCAS_ERR_MAXDUR    3'h7

`endif

// file: src/lcas_pkg.sv
// Types shared by the loop alignment supervisor files.
package lcas_pkg;

  typedef enum logic [1:0] {
    LCAS_IDLE  = 2'b00,
    LCAS_ALIGN = 2'b01,
    LCAS_NEXT  = 2'b10
  } lcas_seq_t;

  typedef logic [2:0] lcas_err_t;

endpackage

// file: src/lcas_supervisor.sv
// Alignment sequencing, fault classification and indicators, four channels.
`timescale 1ns/1ps
`default_nettype none
`include "lcas_defines.svh"

module lcas_supervisor
  import lcas_pkg::*;
#(
  parameter int NCH          = 4,                // Channel count.
  parameter int CYC_PER_MS   = `LCAS_CYC_PER_MS, // Clock cycles per ms.
  parameter int ALIGN_CYC    = `LCAS_ALIGN_MS * `LCAS_CYC_PER_MS,
  parameter int DISTURB_CYC  = `LCAS_DISTURB_MS * `LCAS_CYC_PER_MS,
  parameter int RECAL_CYC    = `LCAS_RECAL_MS * `LCAS_CYC_PER_MS,
  parameter int BURST_CYC    = `LCAS_BURST_MS * `LCAS_CYC_PER_MS,
  parameter int BLINK_CYC    = `LCAS_BLINK_MS * `LCAS_CYC_PER_MS,
  parameter int FAST_CYC     = `LCAS_FAST_HALF_MS * `LCAS_CYC_PER_MS,
  parameter int NORM_CYC     = `LCAS_NORM_HALF_MS * `LCAS_CYC_PER_MS,
  parameter int SYNC_CYC     = `LCAS_SYNC_HALF_MS * `LCAS_CYC_PER_MS,
  parameter int PRESS_TOG    = `LCAS_PRESS_TOG_MS * `LCAS_CYC_PER_MS,
  parameter int PRESS_ALN    = `LCAS_PRESS_ALN_MS * `LCAS_CYC_PER_MS,
  parameter int PRESS_RST    = `LCAS_PRESS_RST_MS * `LCAS_CYC_PER_MS
) (
  input  wire logic             core_clk,           // 25 MHz clock.
  input  wire logic             rst_n,              // Async reset, low.
  input  wire logic             internal_reset,     // Watchdog/power fail.
  input  wire logic             if_reset_req,       // Interface reset pulse.
  input  wire logic             param_xfer,         // Transfer done pulse.
  input  wire logic [NCH-1:0]   param_changed,      // Changed channels.
  input  wire logic [NCH-1:0]   chan_selected,      // Selected channels.
  input  wire logic [NCH-1:0]   chan_active,        // Channel enabled.
  input  wire logic [NCH/2-1:0] dir_logic_en,       // Pair directional.
  input  wire logic [NCH-1:0]   auto_recal_en,      // Per-channel recal.
  input  wire logic             sync_active,        // Master-slave sync.
  input  wire logic [15:0]      max_align_ms,       // Maximum duration.
  input  wire logic             front_reset_button, // Button, high pressed.
  input  wire logic             meas_settled,       // Aligned channel done.
  input  wire logic             meas_ind_low,       // Inductance low.
  input  wire logic             meas_ind_high,      // Inductance high.
  input  wire logic             meas_freq_fail,     // Range not reachable.
  input  wire logic [NCH-1:0]   raw_detect,         // Raw detection.
  output var  logic [1:0]       align_chan,         // Channel aligning.
  output var  logic             align_busy,         // Alignment running.
  output var  logic [NCH-1:0]   detect_out,         // Qualified detection.
  output var  logic [3*NCH-1:0] chan_error,         // Error codes, 3b each.
  output var  logic             error_indicator,    // Collective error.
  output var  logic             function_indicator, // Function lamp.
  output var  logic             channel_one_indicator,  // Lamp 1.
  output var  logic             channel_two_indicator,  // Lamp 2.
  output var  logic             channel_three_indicator, // Lamp 3.
  output var  logic             channel_four_indicator  // Lamp 4.
);

  initial begin
    if (NCH != 4) begin
      $error("lcas_supervisor: four channels supported");
    end
    if (DISTURB_CYC <= ALIGN_CYC || CYC_PER_MS < 1) begin
      $error("lcas_supervisor: inconsistent timing parameters");
    end
  end

  // Error code of one channel from the packed vector.
  function automatic lcas_err_t err_of(input logic [3*NCH-1:0] v,
                                       input int idx);
    err_of = v[3*idx +: 3];
  endfunction

  // =========================================================================
  // Pushbutton press length
  logic [31:0] press_r;
  logic [31:0] press_nxt;
  logic        btn_r;
  logic        lamps_on_r;
  logic        lamps_on_nxt;
  logic        btn_align;
  logic        btn_reset;

  // Release decides the action from the held length.
  always_comb begin
    press_nxt    = press_r;
    lamps_on_nxt = lamps_on_r;
    btn_align    = 1'b0;
    btn_reset    = 1'b0;
    if (front_reset_button) begin
      press_nxt = (press_r == 32'hFFFF_FFFF) ? press_r
                                             : press_r + 32'h0000_0001;
    end else begin
      press_nxt = 32'h0000_0000;
      if (btn_r) begin
        if (press_r < 32'(PRESS_TOG)) begin
          lamps_on_nxt = ~lamps_on_r;
        end else if (press_r <= 32'(PRESS_ALN)) begin
          btn_align = 1'b1;
        end else if (press_r > 32'(PRESS_RST)) begin
          btn_reset = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      press_r    <= 32'h0000_0000;
      btn_r      <= 1'b0;
      lamps_on_r <= 1'b1;
    end else begin
      press_r    <= press_nxt;
      btn_r      <= front_reset_button;
      lamps_on_r <= lamps_on_nxt;
    end
  end

  // =========================================================================
  // Alignment requests and the multiplexed sequencer
  logic [NCH-1:0] pend_r;
  logic [NCH-1:0] pend_nxt;
  logic [NCH-1:0] ok_r;
  logic [NCH-1:0] ok_nxt;
  logic [NCH-1:0] block_r;
  logic [NCH-1:0] block_nxt;
  logic [3*NCH-1:0] err_r;
  logic [3*NCH-1:0] err_nxt;
  logic [31:0]    recal_r;
  logic [31:0]    recal_nxt;
  lcas_seq_t      st_r;
  lcas_seq_t      st_nxt;
  logic [1:0]     ch_r;
  logic [1:0]     ch_nxt;
  logic [31:0]    tmr_r;
  logic [31:0]    tmr_nxt;
  logic           powerup_r;
  logic [NCH-1:0] fault_own;
  logic [31:0]    max_cyc;
  logic           any_reset;

  assign any_reset = powerup_r | internal_reset | if_reset_req | btn_reset;
  assign max_cyc   = 32'(max_align_ms) * 32'(CYC_PER_MS);

  // Own faults are those other than the partner error.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      fault_own[i] = (err_of(err_r, i) != `LCAS_ERR_NONE) &&
                     (err_of(err_r, i) != `LCAS_ERR_PARTNER);
    end
  end

  always_comb begin
    pend_nxt  = pend_r;
    ok_nxt    = ok_r;
    block_nxt = block_r;
    err_nxt   = err_r;
    st_nxt    = st_r;
    ch_nxt    = ch_r;
    tmr_nxt   = tmr_r;
    recal_nxt = recal_r + 32'h0000_0001;
    if (any_reset) begin
      pend_nxt = {NCH{1'b1}};
      err_nxt  = '0;
    end else begin
      if (btn_align) begin
        pend_nxt = pend_nxt | chan_active;
      end
      if (param_xfer) begin
        pend_nxt = pend_nxt | (param_changed & chan_selected);
      end
      if (recal_r >= 32'(RECAL_CYC)) begin
        recal_nxt = 32'h0000_0000;
        pend_nxt  = pend_nxt | (fault_own & auto_recal_en);
      end
    end
    // Directional pairs: an own fault in one channel disables the other.
    for (int p = 0; p < NCH / 2; p++) begin
      for (int k = 0; k < 2; k++) begin
        if (dir_logic_en[p] && fault_own[2*p+1-k] && !fault_own[2*p+k]) begin
          err_nxt[3*(2*p+k) +: 3] = `LCAS_ERR_PARTNER;
        end else if (err_of(err_r, 2*p+k) == `LCAS_ERR_PARTNER &&
                     !(dir_logic_en[p] && fault_own[2*p+1-k])) begin
          err_nxt[3*(2*p+k) +: 3] = `LCAS_ERR_NONE;
          pend_nxt[2*p+k]        = 1'b1;
        end
      end
    end
    unique case (st_r)
      LCAS_IDLE: begin
        if (!any_reset && pend_r[ch_r]) begin
          st_nxt          = LCAS_ALIGN;
          tmr_nxt         = 32'h0000_0000;
          ok_nxt[ch_r]    = 1'b0;
          block_nxt[ch_r] = raw_detect[ch_r];
        end else begin
          ch_nxt = ch_r + 2'h1;
        end
      end
      LCAS_ALIGN: begin
        tmr_nxt = tmr_r + 32'h0000_0001;
        block_nxt[ch_r] = block_r[ch_r] | raw_detect[ch_r];
        if (any_reset) begin
          st_nxt = LCAS_IDLE;
        end else if (meas_ind_low) begin
          err_nxt[3*ch_r +: 3] = `LCAS_ERR_SHORT;
          st_nxt = LCAS_NEXT;
        end else if (meas_ind_high) begin
          err_nxt[3*ch_r +: 3] = `LCAS_ERR_OPEN;
          st_nxt = LCAS_NEXT;
        end else if (meas_freq_fail) begin
          err_nxt[3*ch_r +: 3] = `LCAS_ERR_FREQ;
          st_nxt = LCAS_NEXT;
        end else if (max_align_ms != 16'h0000 && tmr_r >= max_cyc) begin
          err_nxt[3*ch_r +: 3] = `LCAS_ERR_MAXDUR;
          st_nxt = LCAS_NEXT;
        end else if ((meas_settled && tmr_r >= 32'(ALIGN_CYC - 1)) ||
                     tmr_r >= 32'(DISTURB_CYC)) begin
          // Honour settling after a second; stop at the disturb limit.
          err_nxt[3*ch_r +: 3] = (tmr_r >= 32'(DISTURB_CYC)) ?
                                 `LCAS_ERR_DISTURB : `LCAS_ERR_NONE;
          ok_nxt[ch_r] = (tmr_r < 32'(DISTURB_CYC));
          st_nxt = LCAS_NEXT;
        end
      end
      LCAS_NEXT: begin
        pend_nxt[ch_r] = 1'b0;
        ch_nxt         = ch_r + 2'h1;
        st_nxt         = LCAS_IDLE;
      end
      default: begin
        st_nxt = LCAS_IDLE;
      end
    endcase
    if (any_reset) begin
      ch_nxt   = 2'h0;
      pend_nxt = {NCH{1'b1}};
    end
    // A vehicle held over alignment stays masked until it leaves.
    for (int i = 0; i < NCH; i++) begin
      if (!raw_detect[i] && !(st_r == LCAS_ALIGN && ch_r == 2'(i))) begin
        block_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r    <= '0;
      ok_r      <= '0;
      block_r   <= '0;
      err_r     <= '0;
      st_r      <= LCAS_IDLE;
      ch_r      <= 2'h0;
      tmr_r     <= 32'h0000_0000;
      recal_r   <= 32'h0000_0000;
      powerup_r <= 1'b1;
    end else begin
      pend_r    <= pend_nxt;
      ok_r      <= ok_nxt;
      block_r   <= block_nxt;
      err_r     <= err_nxt;
      st_r      <= st_nxt;
      ch_r      <= ch_nxt;
      tmr_r     <= tmr_nxt;
      recal_r   <= recal_nxt;
      powerup_r <= 1'b0;
    end
  end

  // =========================================================================
  // Qualified detection and status outputs
  logic [NCH-1:0] det_r;
  logic [NCH-1:0] det_nxt;
  logic [NCH-1:0] aln_vec;
  logic           busy_r;
  logic [1:0]     ach_r;
  logic           errled_r;
  logic [3*NCH-1:0] cerr_r;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      aln_vec[i] = (st_r == LCAS_ALIGN) && (ch_r == 2'(i));
      det_nxt[i] = raw_detect[i] && ok_r[i] && !pend_r[i] &&
                   !block_r[i] && chan_active[i] &&
                   (err_of(err_r, i) == `LCAS_ERR_NONE);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_r    <= '0;
      busy_r   <= 1'b0;
      ach_r    <= 2'h0;
      errled_r <= 1'b0;
      cerr_r   <= '0;
    end else begin
      det_r    <= det_nxt;
      busy_r   <= (st_r == LCAS_ALIGN);
      ach_r    <= ch_r;
      errled_r <= |fault_own | (|err_r);
      cerr_r   <= err_r;
    end
  end

  assign detect_out      = det_r;
  assign align_busy      = busy_r;
  assign align_chan      = ach_r;
  assign error_indicator = errled_r & lamps_on_r;
  assign chan_error      = cerr_r;

  // =========================================================================
  // Function indicator flash rate
  logic [31:0] fct_r;
  logic [31:0] fct_nxt;
  logic        fled_r;
  logic        fled_nxt;
  logic [31:0] half_cyc;

  always_comb begin
    if (st_r == LCAS_ALIGN) begin
      half_cyc = 32'(FAST_CYC);
    end else if (sync_active) begin
      half_cyc = 32'(SYNC_CYC);
    end else begin
      half_cyc = 32'(NORM_CYC);
    end
    fled_nxt = fled_r;
    fct_nxt  = fct_r + 32'h0000_0001;
    if (fct_r >= half_cyc - 32'h0000_0001) begin
      fct_nxt  = 32'h0000_0000;
      fled_nxt = ~fled_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fct_r  <= 32'h0000_0000;
      fled_r <= 1'b0;
    end else begin
      fct_r  <= fct_nxt;
      fled_r <= fled_nxt;
    end
  end

  assign function_indicator = fled_r & lamps_on_r;

  // =========================================================================
  // Channel indicators
  logic [NCH-1:0] led_raw;
  logic [NCH-1:0] led_q;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_led
      lcas_blinker #(
        .BURST_CYC (BURST_CYC),
        .BLINK_CYC (BLINK_CYC)
      ) u_blink (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .err_code (err_of(err_r, g)),
        .aligning (aln_vec[g]),
        .detect   (det_r[g]),
        .led      (led_raw[g])
      );
      assign led_q[g] = led_raw[g] & lamps_on_r;
    end
  endgenerate

  assign channel_one_indicator   = led_q[0];
  assign channel_two_indicator   = led_q[1];
  assign channel_three_indicator = led_q[2];
  assign channel_four_indicator  = led_q[3];

endmodule
`default_nettype wire

// file: verification/lcas_loop_model.sv
// Loop measurement model: settles or faults the channel being aligned.
`timescale 1ns/1ps
`default_nettype none

module lcas_loop_model (
  input  wire logic       core_clk,       // Clock.
  input  wire logic       rst_n,          // Reset, active low.
  input  wire logic       align_busy,     // Alignment running.
  input  wire logic [1:0] align_chan,     // Channel aligning.
  input  wire logic [2:0] mode,           // 0 good, 1..3 fault, 4 noisy.
  input  wire logic [1:0] bad_chan,       // Channel that misbehaves.
  output var  logic       meas_settled,   // Loop settled.
  output var  logic       meas_ind_low,   // Inductance too low.
  output var  logic       meas_ind_high,  // Inductance too high.
  output var  logic       meas_freq_fail  // Range unreachable.
);
  logic [7:0] cnt_r;
  logic       tog_r;
  logic       bad;

  // Cycles into the alignment; a toggle fills the idle time.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      tog_r <= 1'b0;
    end else begin
      cnt_r <= align_busy ? cnt_r + 8'h01 : 8'h00;
      tog_r <= !tog_r;
    end
  end

  // Faults wait two cycles so they never land on a neighbour channel.
  assign bad = align_busy && align_chan == bad_chan && cnt_r >= 8'h02;

  // Measurement answers for the selected behaviour.
  always_comb begin
    meas_ind_low   = bad && mode == 3'h1;
    meas_ind_high  = bad && mode == 3'h2;
    meas_freq_fail = bad && mode == 3'h3;
    meas_settled   = align_busy ? !(bad && mode == 3'h4) : tog_r;
  end
endmodule
`default_nettype wire

// file: verification/lcas_supervisor_props.sv
// Concurrent checks on the loop alignment supervisor ports.
`timescale 1ns/1ps
`default_nettype none

module lcas_supervisor_props #(
  parameter int ALIGN_CYC   = 20, // Undisturbed alignment length.
  parameter int DISTURB_CYC = 40, // Disturbance cut-off.
  parameter int FAST_CYC    = 4,  // Fast flash half period.
  parameter int CYC_PER_MS  = 1   // Cycles per millisecond.
) (
  input wire logic        core_clk,              // Clock.
  input wire logic        rst_n,                 // Reset, active low.
  input wire logic [15:0] max_align_ms,          // Duration cap.
  input wire logic        meas_ind_low,          // Inductance low.
  input wire logic        meas_ind_high,         // Inductance high.
  input wire logic        meas_freq_fail,        // Range unreachable.
  input wire logic [1:0]  align_chan,            // Channel aligning.
  input wire logic        align_busy,            // Alignment running.
  input wire logic [3:0]  detect_out,            // Qualified detection.
  input wire logic [11:0] chan_error,            // Error codes.
  input wire logic        error_indicator,       // Collective lamp.
  input wire logic        function_indicator,    // Function lamp.
  input wire logic        channel_one_indicator  // Lamp of channel 0.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Helper counters
  logic [15:0] blen_r;
  logic [15:0] frun_r;
  logic        fi_q_r;
  logic        flt_r;

  // Length of the running alignment, faults seen in it, flash run.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blen_r <= 16'h0000;
      frun_r <= 16'h0000;
      fi_q_r <= 1'b0;
      flt_r  <= 1'b0;
    end else begin
      blen_r <= align_busy ? blen_r + 16'h0001 : 16'h0000;
      flt_r  <= align_busy && (flt_r || meas_ind_low || meas_ind_high ||
                               meas_freq_fail);
      fi_q_r <= function_indicator;
      frun_r <= (function_indicator != fi_q_r) ? 16'h0000 : frun_r + 16'h0001;
    end
  end

  // ==========================================================
  // Assertions
  reset_realign_a: assert property (
    $rose(rst_n) |-> ##[0:8] align_busy && align_chan == 2'h0)
    else $error("no alignment of channel 0 after reset");
  no_detect_a: assert property (
    align_busy && blen_r >= 16'h0002 |-> !detect_out[align_chan])
    else $error("detection reported while aligning");
  lamp_lit_a: assert property (
    align_busy && blen_r >= 16'h0002 && align_chan == 2'h0
    |-> channel_one_indicator) else $error("lamp dark during alignment");
  fast_flash_a: assert property (
    blen_r >= 16'h0010 |-> int'(frun_r) < FAST_CYC)
    else $error("function lamp not fast during alignment");
  min_len_a: assert property (
    $fell(align_busy) && !flt_r &&
    (max_align_ms == 16'h0000 || int'(max_align_ms) * CYC_PER_MS >= ALIGN_CYC)
    |-> int'(blen_r) >= ALIGN_CYC - 2) else $error("alignment too short");
  disturb_cap_a: assert property (
    int'(blen_r) <= DISTURB_CYC + 2) else $error("alignment too long");
  maxdur_cap_a: assert property (
    max_align_ms != 16'h0000
    |-> int'(blen_r) <= int'(max_align_ms) * CYC_PER_MS + 2)
    else $error("alignment beyond the duration cap");
  end_clear_a: assert property (
    $fell(align_busy) |-> !detect_out[$past(align_chan)])
    else $error("channel detected at end of alignment");
  err_lamp_a: assert property (
    chan_error == 12'h000 && $past(chan_error) == 12'h000 |-> !error_indicator)
    else $error("error lamp without an error");
  no_five_a: assert property (
    chan_error[2:0] != 3'h5 && chan_error[5:3] != 3'h5 &&
    chan_error[8:6] != 3'h5 && chan_error[11:9] != 3'h5)
    else $error("reserved error code shown");

  // Main scenarios reached.
  cover property ($fell(align_busy));
  cover property ($rose(error_indicator));
  cover property (blen_r >= 16'h0024);
endmodule

bind lcas_supervisor lcas_supervisor_props #(
  .ALIGN_CYC(ALIGN_CYC), .DISTURB_CYC(DISTURB_CYC), .FAST_CYC(FAST_CYC),
  .CYC_PER_MS(CYC_PER_MS)
) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .max_align_ms(max_align_ms),
  .meas_ind_low(meas_ind_low), .meas_ind_high(meas_ind_high),
  .meas_freq_fail(meas_freq_fail), .align_chan(align_chan),
  .align_busy(align_busy), .detect_out(detect_out), .chan_error(chan_error),
  .error_indicator(error_indicator), .function_indicator(function_indicator),
  .channel_one_indicator(channel_one_indicator)
);
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the loop alignment supervisor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic internal_reset = 1'b0, if_reset_req = 1'b0, param_xfer = 1'b0;
  logic sync_active = 1'b0, btn = 1'b0, busy_q = 1'b0;
  logic [3:0] param_changed = 4'h0, chan_selected = 4'h0;
  logic [3:0] chan_active = 4'hf, auto_recal_en = 4'h0, raw_detect = 4'h0;
  logic [1:0] dir_logic_en = 2'h0, bad_chan = 2'h0, align_chan;
  logic [15:0] max_align_ms = 16'h0000;
  logic [2:0] mode = 3'h0;
  logic meas_settled, meas_ind_low, meas_ind_high, meas_freq_fail;
  logic align_busy, error_indicator, function_indicator;
  logic [3:0] detect_out, led;
  logic [11:0] chan_error;
  logic [1:0] seen[$];
  int error_cnt = 0;
  int n_compared = 0;

  localparam int T = 20; // Cycles of a nominal alignment.
  lcas_supervisor #(.ALIGN_CYC(T), .DISTURB_CYC(2*T), .RECAL_CYC(10*T),
    .BURST_CYC(20*T), .BLINK_CYC(T), .FAST_CYC(T/5), .NORM_CYC(T/2),
    .SYNC_CYC(T), .PRESS_TOG(T/2), .PRESS_ALN(T), .PRESS_RST(3*T/2),
    .CYC_PER_MS(1)) u_lcas_supervisor (.core_clk, .rst_n, .internal_reset,
    .if_reset_req, .param_xfer, .param_changed, .chan_selected, .chan_active,
    .dir_logic_en, .auto_recal_en, .sync_active, .max_align_ms,
    .front_reset_button(btn), .meas_settled, .meas_ind_low, .meas_ind_high,
    .meas_freq_fail, .raw_detect, .align_chan, .align_busy, .detect_out,
    .chan_error, .error_indicator, .function_indicator,
    .channel_one_indicator(led[0]), .channel_two_indicator(led[1]),
    .channel_three_indicator(led[2]), .channel_four_indicator(led[3]));

  lcas_loop_model u_lcas_loop_model (.core_clk, .rst_n, .align_busy,
    .align_chan, .mode, .bad_chan, .meas_settled, .meas_ind_low,
    .meas_ind_high, .meas_freq_fail);

  // ==========================================================
  // Clock, alignment log and watchdog
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // Logs the channel of every alignment start.
  always @(posedge core_clk) begin
    if (align_busy === 1'b1 && busy_q !== 1'b1) seen.push_back(align_chan);
    busy_q = align_busy;
  end

  // The tests need about 4000 cycles; 50000 means a hang.
  initial begin
    #2000000;
    error_cnt++;
    print_verdict();
  end

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  // One-cycle request pulse; the log starts afresh.
  task automatic strobe(ref logic s);
    seen.delete();
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  task automatic press(input int n);
    seen.delete();
    btn = 1'b1;
    tick(n);
    btn = 0;
  endtask

  // Waits until no alignment has run for twelve cycles.
  task automatic settle();
    int q;
    int t;
    q = 0;
    t = 0;
    while (q < 12 && t < 3000) begin
      tick(1);
      q = (align_busy === 1'b0) ? q + 1 : 0;
      t++;
    end
    if (t >= 3000) error_cnt++;
  endtask

  // Compares the logged alignments with the channels in m, ascending.
  task automatic chk_seq(input logic [3:0] m);
    logic [1:0] e[$];
    for (int c = 0; c < 4; c++) if (m[c]) e.push_back(2'(c));
    `CHK(seen.size(), e.size())
    foreach (e[i]) if (i < seen.size()) `CHK(seen[i], e[i])
  endtask

  // Counts lamp blinks over one burst period.
  task automatic blinks(input int c, input int exp);
    int n;
    logic p;
    n = 0;
    p = led[c];
    repeat (400) begin
      tick(1);
      if (led[c] === 1'b1 && p !== 1'b1) n++;
      p = led[c];
    end
    `CHK(n, exp)
  endtask

  // Measures the function lamp half period, the third one seen.
  task automatic half(input int exp);
    int n;
    logic p;
    for (int k = 0; k < 3; k++) begin
      p = function_indicator;
      n = 0;
      while (function_indicator === p && n < 100) begin
        tick(1);
        n++;
      end
    end
    `CHK(n, exp)
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    tick(3);
    rst_n = 1'b1;
    settle();
    chk_seq(4'hf);
    `CHK(chan_error, 12'h000)
    raw_detect = 4'h5;
    tick(3);
    `CHK(detect_out, 4'h5)
    `CHK(led[1:0], 2'h1)
    raw_detect = 4'h7;
    param_changed = 4'h3;
    chan_selected = 4'h6;
    strobe(param_xfer);
    tick(8);
    `CHK(detect_out[2], 1'b1)
    settle();
    chk_seq(4'h2);
    `CHK(detect_out, 4'h5)
    raw_detect = 4'h0;
    dir_logic_en = 2'h2;
    bad_chan = 2'h2;
    for (int m = 1; m < 5; m++) begin
      mode = 3'(m);
      strobe(if_reset_req);
      settle();
      chk_seq(4'hf);
      `CHK(chan_error[8:6], 3'(m))
      if (m < 4) `CHK(chan_error[11:9], 3'h6)
      `CHK(error_indicator, 1'b1)
      blinks(2, m);
      if (m == 1) blinks(3, 6);
    end
    dir_logic_en = 2'h0;
    mode = 3'h0;
    max_align_ms = 16'h000a;
    strobe(internal_reset);
    settle();
    `CHK(chan_error, 12'hfff)
    blinks(3, 7);
    max_align_ms = 16'h0000;
    auto_recal_en = 4'h4;
    mode = 3'h2;
    strobe(if_reset_req);
    settle();
    `CHK(chan_error, 12'h080)
    mode = 3'h0;
    seen.delete();
    tick(250);
    settle();
    chk_seq(4'h4);
    `CHK(chan_error, 12'h000)
    auto_recal_en = 4'h0;
    chan_active = 4'h2;
    press(15);
    settle();
    chk_seq(4'h2);
    chan_active = 4'hf;
    raw_detect = 4'h1;
    tick(3);
    press(5);
    tick(3);
    `CHK(led[0], 1'b0)
    press(5);
    tick(3);
    `CHK(led[0], 1'b1)
    press(35);
    settle();
    chk_seq(4'hf);
    half(10);
    sync_active = 1'b1;
    half(20);
    print_verdict();
  end
endmodule
`default_nettype wire
